// File: rfb_pkg.sv
// register bank select package: addresses, bank codes, field positions and reset values
// assumes a single 8-bit core clock domain with a synchronous active-high reset
// Summary of operation
// - 256-byte file: ports, control, general storage
// - pointer upper nibble picks 16-byte working group
// - pointer lower nibble selects bank; 0, F, D
// - bank zero leaves normal register file visible
// - nonzero bank replaces lowest sixteen locations
// - pointer zero maps registers 0-3 to ports
// - stack lives in R4-R239, pointer at R255
// - R254 is ordinary general-purpose storage
// - lowest twelve program bytes hold six vectors
// - high-level capture holds count while input high
// - low-level capture holds count while input low
// - wide capture split into high and low bytes
package rfb_pkg;
    localparam int RFB_FILE_BYTES = 256;
    localparam int RFB_PORT_COUNT = 4;
    localparam logic [7:0] RFB_ADDR_GP_FIRST = 8'h04;
    localparam logic [7:0] RFB_ADDR_GROUP_PTR = 8'hfd;
    localparam logic [7:0] RFB_ADDR_SP_UPPER = 8'hfe;
    localparam logic [7:0] RFB_ADDR_SP = 8'hff;
    localparam logic [7:0] RFB_STACK_LOW = 8'h04;
    localparam logic [7:0] RFB_STACK_HIGH = 8'hef;
    localparam logic [7:0] RFB_SP_RESET = 8'hf0;
    localparam logic [7:0] RFB_GROUP_PTR_RESET = 8'h00;

    localparam logic [3:0] RFB_BANK_NORMAL = 4'h0;
    localparam logic [3:0] RFB_BANK_F = 4'hf;
    localparam logic [3:0] RFB_BANK_D = 4'hd;

    // bank D register indices
    localparam logic [3:0] RFB_D_SHORT_TIMER_CONTROL = 4'h0;
    localparam logic [3:0] RFB_D_SHARED_TIMER_CONTROL = 4'h1;
    localparam logic [3:0] RFB_D_WIDE_TIMER_CONTROL = 4'h2;
    localparam logic [3:0] RFB_D_TIMER_ENABLE_CONTROL = 4'h3;
    localparam logic [3:0] RFB_D_WIDE_RELOAD_HIGH = 4'h7;
    localparam logic [3:0] RFB_D_WIDE_CAPTURE_LOW = 4'h8;
    localparam logic [3:0] RFB_D_WIDE_CAPTURE_HIGH = 4'h9;
    localparam logic [3:0] RFB_D_SHORT_CAPTURE_LOW = 4'ha;
    localparam logic [3:0] RFB_D_SHORT_CAPTURE_HIGH = 4'hb;

    // timer enable control: bits 4:0 read as ones, upper three are live
    localparam int RFB_EN_SYNC_BIT = 5;
    localparam int RFB_EN_SHORT_BIT = 6;
    localparam int RFB_EN_WIDE_BIT = 7;
    localparam logic [4:0] RFB_EN_RESERVED_READ = 5'h1f;
    localparam logic [2:0] RFB_EN_RESET = 3'h0;
    localparam logic [7:0] RFB_CTRL_RESET = 8'h00;

    localparam int RFB_VECTOR_COUNT = 6;
    localparam int RFB_VECTOR_BYTES = 2;
    localparam int RFB_PROG_ADDR_W = 16;
endpackage : rfb_pkg

// File: rfb_decode_if.sv
// access decode carrier between the register bank top and its address decoder
// assumes both ends sit in the same clock domain; contents are purely combinational
`timescale 1ns/1ps
interface rfb_decode_if;
    logic [7:0] group_ptr;
    logic short_ref;
    logic [3:0] index;
    logic [7:0] full_addr;
    logic [7:0] eff_addr;
    logic [3:0] bank;
    logic swap;

    modport requester (
        output group_ptr,
        output short_ref,
        output index,
        output full_addr,
        input eff_addr,
        input bank,
        input swap
    );
    modport decoder (
        input group_ptr,
        input short_ref,
        input index,
        input full_addr,
        output eff_addr,
        output bank,
        output swap
    );
endinterface : rfb_decode_if

// File: rfb_addr_decode.sv
// address decoder: effective register address and bank substitution
// assumes the requester holds the pointer and request stable for the cycle
`timescale 1ns/1ps
module rfb_addr_decode (
    rfb_decode_if.decoder dec
);
    import rfb_pkg::*;

    // short references land inside the group picked by the upper nibble
    assign dec.eff_addr = dec.short_ref ? {dec.group_ptr[7:4], dec.index} : dec.full_addr;
    assign dec.bank = dec.group_ptr[3:0];
    // only the lowest sixteen locations are exchanged, and only for a nonzero bank
    assign dec.swap = (dec.bank != RFB_BANK_NORMAL) && (dec.eff_addr[7:4] == 4'h0);
endmodule : rfb_addr_decode

// File: rfb_register_bank.sv
// register file with expanded bank select, stack pointer and vector lookup
// assumes the core issues at most one read or write per clock, all on clk_sys
`timescale 1ns/1ps
module rfb_register_bank #(
    parameter int FILE_BYTES = rfb_pkg::RFB_FILE_BYTES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic acc_short,
    input wire logic [3:0] acc_index,
    input wire logic [7:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [7:0] acc_wdata,
    input wire logic [31:0] port_in,
    input wire logic cap8_load_high,
    input wire logic cap8_load_low,
    input wire logic [7:0] cap8_count,
    input wire logic cap16_load,
    input wire logic [15:0] cap16_count,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic [7:0] stack_wdata,
    input wire logic irq_take,
    input wire logic [2:0] irq_source,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic [31:0] port_out,
    output logic [23:0] timer_ctrl,
    output logic [2:0] timer_enables,
    output logic [7:0] wide_reload_high,
    output logic [7:0] group_ptr,
    output logic [7:0] stack_ptr,
    output logic stack_fault,
    output logic [rfb_pkg::RFB_PROG_ADDR_W-1:0] vector_addr
);
    import rfb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    // storage
    // R0..R3 are never storage: the ports or a bank answer there
    logic [7:0] gp_mem [4:FILE_BYTES-1];
    logic [7:0] bank_f_mem [0:15];
    logic [7:0] port_reg [0:RFB_PORT_COUNT-1];
    logic [7:0] timer_ctrl_reg [0:2];
    logic [2:0] enable_reg;
    logic [7:0] reload_high_reg;
    logic [7:0] wide_cap_low_reg;
    logic [7:0] wide_cap_high_reg;
    logic [7:0] short_cap_low_reg;
    logic [7:0] short_cap_high_reg;
    logic [7:0] rd_data_reg;
    logic rd_valid_reg;
    logic stack_fault_reg;
    logic [RFB_PROG_ADDR_W-1:0] vector_reg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // decode
    rfb_decode_if dec_if ();

    assign dec_if.group_ptr = gp_mem[RFB_ADDR_GROUP_PTR];
    assign dec_if.short_ref = acc_short;
    assign dec_if.index = acc_index;
    assign dec_if.full_addr = acc_addr;

    rfb_addr_decode u_decode (
        .dec(dec_if.decoder)
    );

    // a bank only shows through the low sixteen when the decoder has asked for a swap
    function automatic logic bank_hit(input logic swap_req, input logic [3:0] bank_sel,
        input logic [3:0] code);
        bank_hit = swap_req && (bank_sel == code);
    endfunction : bank_hit

    wire logic [7:0] eff = dec_if.eff_addr;
    wire logic [3:0] sub = eff[3:0];
    wire logic in_bank_f = bank_hit(dec_if.swap, dec_if.bank, RFB_BANK_F);
    wire logic in_bank_d = bank_hit(dec_if.swap, dec_if.bank, RFB_BANK_D);
    // unimplemented banks still hide the low sixteen: reads give zero, writes vanish
    wire logic in_ports = !dec_if.swap && (eff < RFB_ADDR_GP_FIRST);
    wire logic in_gp = !dec_if.swap && (eff >= RFB_ADDR_GP_FIRST);

    // write enables: an unimplemented bank matches none of them; d_we fires for any bank D offset
    wire logic gp_we = acc_wr && in_gp;
    wire logic port_we = acc_wr && in_ports;
    wire logic f_we = acc_wr && in_bank_f;
    wire logic d_we = acc_wr && in_bank_d;

    ////////////////////////////////////////////////////////////////////////////////////////
    // stack pointer movement
    // the stack grows downward from an empty pointer
    wire logic [7:0] sp = gp_mem[RFB_ADDR_SP];
    wire logic push_ok = stack_push && (sp > RFB_STACK_LOW);
    wire logic pop_ok = stack_pop && !stack_push && (sp <= RFB_STACK_HIGH);
    wire logic push_refused = stack_push && !push_ok;
    wire logic pop_refused = stack_pop && !stack_push && !pop_ok;
    // a refused move leaves the pointer where it was and only raises the fault pulse
    wire logic stack_bad = push_refused || pop_refused;
    wire logic [7:0] sp_next = push_ok ? sp - 8'h01 : sp + 8'h01;
    // a core write to the pointer in the same cycle takes precedence over movement
    wire logic sp_move = (push_ok || pop_ok) && !(gp_we && (eff == RFB_ADDR_SP));

    ////////////////////////////////////////////////////////////////////////////////////////
    // read selection
    wire logic [7:0] enable_read = {enable_reg, RFB_EN_RESERVED_READ};
    logic [7:0] d_read;
    always_comb
    begin
        unique case (sub)
            RFB_D_SHORT_TIMER_CONTROL: d_read = timer_ctrl_reg[0];
            RFB_D_SHARED_TIMER_CONTROL: d_read = timer_ctrl_reg[1];
            RFB_D_WIDE_TIMER_CONTROL: d_read = timer_ctrl_reg[2];
            RFB_D_TIMER_ENABLE_CONTROL: d_read = enable_read;
            RFB_D_WIDE_RELOAD_HIGH: d_read = reload_high_reg;
            RFB_D_WIDE_CAPTURE_LOW: d_read = wide_cap_low_reg;
            RFB_D_WIDE_CAPTURE_HIGH: d_read = wide_cap_high_reg;
            RFB_D_SHORT_CAPTURE_LOW: d_read = short_cap_low_reg;
            RFB_D_SHORT_CAPTURE_HIGH: d_read = short_cap_high_reg;
            default: d_read = 8'h00;
        endcase
    end

    // port reads return the pins, not the output latches
    wire logic [7:0] port_read = port_in[eff[1:0]*8 +: 8];
    wire logic [7:0] gp_read = gp_mem[eff];
    wire logic [7:0] f_read = bank_f_mem[sub];
    // an unimplemented bank falls through every term and reads as zero
    wire logic [7:0] rd_next = in_gp ? gp_read :
                               in_ports ? port_read :
                               in_bank_f ? f_read :
                               in_bank_d ? d_read : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////////////
    // main file, stack pointer at the top, group pointer two locations below
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 4; i < FILE_BYTES; i++)
                gp_mem[i] <= 8'h00;
            gp_mem[RFB_ADDR_SP] <= RFB_SP_RESET;
            gp_mem[RFB_ADDR_GROUP_PTR] <= RFB_GROUP_PTR_RESET;
        end
        else
        begin
            if (gp_we)
                gp_mem[eff] <= acc_wdata;
            if (sp_move)
                gp_mem[RFB_ADDR_SP] <= sp_next;
            if (push_ok)
                gp_mem[sp_next] <= stack_wdata;
        end
    end

    // port and bank F storage share one repeated structure
    genvar g;
    generate
        for (g = 0; g < RFB_PORT_COUNT; g++)
        begin : g_port
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    port_reg[g] <= 8'h00;
                else if (port_we && (eff[1:0] == 2'(g)))
                    port_reg[g] <= acc_wdata;
            end
            assign port_out[g*8 +: 8] = port_reg[g];
        end
        // bank F is sixteen plain bytes with no side effects
        for (g = 0; g < 16; g++)
        begin : g_bank_f
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    bank_f_mem[g] <= 8'h00;
                else if (f_we && (sub == 4'(g)))
                    bank_f_mem[g] <= acc_wdata;
            end
        end
        for (g = 0; g < 3; g++)
        begin : g_timer_ctrl
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                    timer_ctrl_reg[g] <= RFB_CTRL_RESET;
                else if (d_we && (sub == 4'(g)))
                    timer_ctrl_reg[g] <= acc_wdata;
            end
            assign timer_ctrl[g*8 +: 8] = timer_ctrl_reg[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////////////
    // bank D: enables, reload byte and capture registers
    wire logic enable_we = d_we && (sub == RFB_D_TIMER_ENABLE_CONTROL);
    wire logic reload_we = d_we && (sub == RFB_D_WIDE_RELOAD_HIGH);
    // reserved low bits of the enable register ignore writes
    wire logic [2:0] enable_next = acc_wdata[RFB_EN_WIDE_BIT:RFB_EN_SYNC_BIT];

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            enable_reg <= RFB_EN_RESET;
        else if (enable_we)
            enable_reg <= enable_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reload_high_reg <= 8'h00;
        else if (reload_we)
            reload_high_reg <= acc_wdata;
    end

    // captures are read-only to the core; only the timer strobes load them
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            short_cap_high_reg <= 8'h00;
        else if (cap8_load_high)
            short_cap_high_reg <= cap8_count;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            short_cap_low_reg <= 8'h00;
        else if (cap8_load_low)
            short_cap_low_reg <= cap8_count;
    end

    // both bytes load on one strobe so the register pair never mixes two counts
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wide_cap_high_reg <= 8'h00;
            wide_cap_low_reg <= 8'h00;
        end
        else if (cap16_load)
        begin
            wide_cap_high_reg <= cap16_count[15:8];
            wide_cap_low_reg <= cap16_count[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // read answer, stack fault and vector lookup
    wire logic vec_ok = irq_take && (irq_source < 3'(RFB_VECTOR_COUNT));
    wire logic [RFB_PROG_ADDR_W-1:0] vec_src = RFB_PROG_ADDR_W'(irq_source);
    wire logic [RFB_PROG_ADDR_W-1:0] vec_step = RFB_PROG_ADDR_W'(RFB_VECTOR_BYTES);
    // the slot address is the source number times the slot size
    wire logic [RFB_PROG_ADDR_W-1:0] vec_next = vec_src * vec_step;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rd_valid_reg <= 1'b0;
        else
            rd_valid_reg <= acc_rd;
    end

    // read data holds between reads, so the core may take it late
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            rd_data_reg <= 8'h00;
        else if (acc_rd)
            rd_data_reg <= rd_next;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            stack_fault_reg <= 1'b0;
        else
            stack_fault_reg <= stack_bad;
    end

    // sources without a vector slot leave the last address standing
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            vector_reg <= '0;
        else if (vec_ok)
            vector_reg <= vec_next;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from its flip-flop
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign timer_enables = enable_reg;
    assign wide_reload_high = reload_high_reg;
    assign group_ptr = gp_mem[RFB_ADDR_GROUP_PTR];
    assign stack_ptr = gp_mem[RFB_ADDR_SP];
    assign stack_fault = stack_fault_reg;
    assign vector_addr = vector_reg;
endmodule : rfb_register_bank

// File: rfb_assertions.sv
// checker on the register bank top ports
// assumes one clock domain; bound from the testbench top file
`timescale 1ns/1ps
module rfb_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic acc_short,
    input wire logic [7:0] acc_addr,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [7:0] acc_wdata,
    input wire logic [31:0] port_in,
    input wire logic stack_push,
    input wire logic irq_take,
    input wire logic [2:0] irq_source,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic [23:0] timer_ctrl,
    input wire logic [2:0] timer_enables,
    input wire logic [7:0] group_ptr,
    input wire logic [7:0] stack_ptr,
    input wire logic stack_fault,
    input wire logic [rfb_pkg::RFB_PROG_ADDR_W-1:0] vector_addr
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    wire full_rd = acc_rd && !acc_short;
    wire full_wr = acc_wr && !acc_short;
    wire low16 = acc_addr[7:4] == 4'h0;
    wire [3:0] bank = group_ptr[3:0];
    // a core write in the same cycle may move the pointer, so it is excluded
    sequence push_ok_s;
        stack_push && !acc_wr && stack_ptr > 8'h04;
    endsequence
    sequence push_bad_s;
        stack_push && !acc_wr && stack_ptr <= 8'h04;
    endsequence
    ////////////////////////////////
    read_pulse_a: assert property (rd_valid == $past(acc_rd))
        else $error("read answer pulse wrong");
    group_write_a: assert property (full_wr && acc_addr == 8'hfd |=> group_ptr == $past(acc_wdata))
        else $error("group pointer not written");
    port_read_a: assert property (full_rd && acc_addr < 8'h04 && bank == 4'h0
        |=> rd_data == $past(port_in[8*acc_addr[1:0] +: 8])) else $error("port read wrong");
    bank_none_a: assert property (full_rd && low16 && bank != 4'h0 && bank != 4'hf
        && bank != 4'hd |=> rd_data == 8'h00) else $error("absent bank read not zero");
    enable_read_a: assert property (full_rd && low16 && bank == 4'hd && acc_addr[3:0] == 4'h3
        |=> rd_data == {$past(timer_enables), 5'h1f}) else $error("enable read wrong");
    ctrl_write_a: assert property (full_wr && low16 && bank == 4'hd && acc_addr[3:0] < 4'h3
        |=> timer_ctrl[8*$past(acc_addr[1:0]) +: 8] == $past(acc_wdata)) else $error("ctrl write");
    push_move_a: assert property (push_ok_s |=> stack_ptr == $past(stack_ptr) - 8'h01)
        else $error("push did not move pointer");
    push_floor_a: assert property (push_bad_s |=> stack_fault && $stable(stack_ptr))
        else $error("push below floor not refused");
    vector_addr_a: assert property (irq_take && irq_source < 3'h6
        |=> vector_addr == {12'h000, $past(irq_source), 1'b0}) else $error("vector address wrong");
endmodule : rfb_assertions

// File: rfb_core_model.sv
// core access model: one register read or write at a time
// assumes the bench calls access from a single process
`timescale 1ns/1ps
module rfb_core_model (
    input wire logic clk_sys,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic acc_short = 1'b0,
    output logic [3:0] acc_index = 4'h0,
    output logic [7:0] acc_addr = 8'h00,
    output logic acc_wr = 1'b0,
    output logic acc_rd = 1'b0,
    output logic [7:0] acc_wdata = 8'h00
);
    task automatic access(input logic s, input logic [7:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] q, output logic v);
        @(posedge clk_sys);
        acc_short <= s;
        acc_index <= a[3:0];
        acc_addr <= a;
        acc_wdata <= d;
        acc_wr <= w;
        acc_rd <= !w;
        @(posedge clk_sys);
        // released address and data lines show the inverse so a stale value never passes as held; strobes drop to zero
        acc_short <= 1'b0;
        acc_index <= ~a[3:0];
        acc_addr <= ~a;
        acc_wdata <= ~d;
        acc_wr <= 1'b0;
        acc_rd <= 1'b0;
        @(negedge clk_sys);
        q = rd_data;
        v = rd_valid;
    endtask : access
endmodule : rfb_core_model

// File: rfb_register_bank_tb_top.sv
// self-checking bench for the register bank top with a core access model
// assumes design, checker and core model are compiled before this file
`timescale 1ns/1ps
module rfb_register_bank_tb_top;
    typedef struct packed {logic [7:0] grp; logic [7:0] addr; logic wr; logic [7:0] wd;
        logic [7:0] exp;} rfb_row_s;
    localparam rfb_row_s ROWS [12] = '{
        '{8'h00, 8'h10, 1'b1, 8'h5a, 8'h5a}, '{8'h00, 8'h05, 1'b1, 8'h77, 8'h77},
        '{8'h0f, 8'h05, 1'b1, 8'h3c, 8'h3c}, '{8'h00, 8'h05, 1'b0, 8'h00, 8'h77},
        '{8'h0d, 8'h07, 1'b1, 8'h96, 8'h96}, '{8'h0d, 8'h08, 1'b1, 8'h11, 8'h00},
        '{8'h0d, 8'h03, 1'b1, 8'he0, 8'hff}, '{8'h0d, 8'h04, 1'b1, 8'h99, 8'h00},
        '{8'h03, 8'h02, 1'b1, 8'h44, 8'h00}, '{8'h00, 8'hfe, 1'b1, 8'ha5, 8'ha5},
        '{8'h00, 8'h01, 1'b0, 8'h00, 8'h22}, '{8'h0d, 8'h01, 1'b1, 8'h12, 8'h12}};
    localparam logic [7:0] CAPS [4] = '{8'h81, 8'h18, 8'hbe, 8'hef};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cap8_load_high = 1'b0, cap8_load_low = 1'b0, cap16_load = 1'b0, v;
    logic stack_push = 1'b0, stack_pop = 1'b0, irq_take = 1'b0;
    logic [7:0] cap8_count = 8'h00, stack_wdata = 8'h00, q;
    logic [15:0] cap16_count = 16'h0000, ve;
    logic [2:0] irq_source = 3'h0;
    logic [31:0] port_in = 32'h4433_2211;
    wire acc_short, acc_wr, acc_rd, rd_valid, stack_fault;
    wire [3:0] acc_index;
    wire [7:0] acc_addr, acc_wdata, rd_data, wide_reload_high, group_ptr, stack_ptr;
    wire [31:0] port_out;
    wire [23:0] timer_ctrl;
    wire [2:0] timer_enables;
    wire [15:0] vector_addr;
    int bad_count = 0;
    int checked = 0;
    always #25 clk_sys = ~clk_sys;
    rfb_core_model rfb_core_model_i (.clk_sys, .rd_data, .rd_valid, .acc_short, .acc_index,
        .acc_addr, .acc_wr, .acc_rd, .acc_wdata);
    rfb_register_bank rfb_register_bank_i (.clk_sys, .rst, .acc_short, .acc_index, .acc_addr,
        .acc_wr, .acc_rd, .acc_wdata, .port_in, .cap8_load_high, .cap8_load_low, .cap8_count,
        .cap16_load, .cap16_count, .stack_push, .stack_pop, .stack_wdata, .irq_take, .irq_source,
        .rd_data, .rd_valid, .port_out, .timer_ctrl, .timer_enables, .wide_reload_high,
        .group_ptr, .stack_ptr, .stack_fault, .vector_addr);
    ////////////////////////////////
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        logic y;
        rfb_core_model_i.access(1'b0, a, 1'b1, d, x, y);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        logic y;
        rfb_core_model_i.access(1'b0, a, 1'b0, 8'h00, x, y);
        chk("rd_valid", 16'h0001, {15'h0000, y});
    endtask : rd
    task automatic stk(input logic pu, input logic po, input logic [7:0] d);
        @(posedge clk_sys);
        stack_push <= pu;
        stack_pop <= po;
        stack_wdata <= d;
        @(posedge clk_sys);
        stack_push <= 1'b0;
        stack_pop <= 1'b0;
        @(negedge clk_sys);
    endtask : stk
    task automatic final_report;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    ////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (ROWS[i])
        begin
            wr(8'hfd, ROWS[i].grp);
            if (ROWS[i].wr)
                wr(ROWS[i].addr, ROWS[i].wd);
            rd(ROWS[i].addr, q);
            chk("row", {8'h00, ROWS[i].exp}, {8'h00, q});
        end
        chk("enables", 16'h0007, {13'h0000, timer_enables});
        chk("ctrl1", 16'h0012, {8'h00, timer_ctrl[15:8]});
        chk("reload", 16'h0096, {8'h00, wide_reload_high});
        wr(8'hfd, 8'h20);
        rfb_core_model_i.access(1'b1, 8'h03, 1'b1, 8'h66, q, v);
        rd(8'h23, q);
        chk("short ref", 16'h0066, {8'h00, q});
        wr(8'hfd, 8'h00);
        wr(8'h02, 8'h5d);
        chk("port2 out", 16'h005d, {8'h00, port_out[23:16]});
        @(posedge clk_sys);
        cap8_count <= 8'h81;
        cap8_load_high <= 1'b1;
        @(posedge clk_sys);
        cap8_load_high <= 1'b0;
        cap8_count <= 8'h18;
        cap8_load_low <= 1'b1;
        @(posedge clk_sys);
        cap8_load_low <= 1'b0;
        cap16_count <= 16'hbeef;
        cap16_load <= 1'b1;
        @(posedge clk_sys);
        cap16_load <= 1'b0;
        wr(8'hfd, 8'h0d);
        for (int j = 0; j < 4; j++)
        begin
            rd(8'h0b - 8'(j), q);
            chk("capture", {8'h00, CAPS[j]}, {8'h00, q});
        end
        for (int s = 0; s < 8; s++)
        begin
            @(posedge clk_sys);
            irq_source <= 3'(s);
            irq_take <= 1'b1;
            @(posedge clk_sys);
            irq_take <= 1'b0;
            @(negedge clk_sys);
            if (s < 6)
                ve = 16'(2 * s);
            chk("vector", ve, vector_addr);
        end
        stk(1'b1, 1'b0, 8'hab);
        chk("sp push", 16'h00ef, {8'h00, stack_ptr});
        rd(8'hef, q);
        chk("stacked", 16'h00ab, {8'h00, q});
        stk(1'b0, 1'b1, 8'h00);
        chk("sp pop", 16'h00f0, {8'h00, stack_ptr});
        stk(1'b0, 1'b1, 8'h00);
        chk("pop fault", 16'h0001, {15'h0000, stack_fault});
        // fill down to the floor, then one push too many
        @(posedge clk_sys);
        stack_push <= 1'b1;
        repeat (237) @(posedge clk_sys);
        stack_push <= 1'b0;
        @(negedge clk_sys);
        chk("sp floor", 16'h0004, {8'h00, stack_ptr});
        chk("push fault", 16'h0001, {15'h0000, stack_fault});
        rd(8'hfe, q);
        chk("r254", 16'h00a5, {8'h00, q});
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        chk("sp reset", 16'h00f0, {8'h00, stack_ptr});
        chk("ptr reset", 16'h0000, {8'h00, group_ptr});
        chk("reload reset", 16'h0000, {8'h00, wide_reload_high});
        final_report();
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        final_report();
    end
endmodule : rfb_register_bank_tb_top
bind rfb_register_bank rfb_assertions rfb_assertions_i (.clk_sys, .rst, .acc_short, .acc_addr,
    .acc_wr, .acc_rd, .acc_wdata, .port_in, .stack_push, .irq_take, .irq_source, .rd_data,
    .rd_valid, .timer_ctrl, .timer_enables, .group_ptr, .stack_ptr, .stack_fault, .vector_addr);
